// File: rtl/pmcm_top.sv
// power-mode and clock manager: APB registers, halt/wake sequencer, oscillator control
`timescale 1ns/100ps
// Overview of operation
// - enabling fast oscillator clears stable flag, sets it after settling time
// - fast oscillator enable is bit 0, one enables, resets to one
// - fast oscillator control bits 7..2 always read zero
// - select code 111 moves system clock to the slow clock
// - slow switch completes only once slow oscillator is stable
// - select codes 000..110 pick fast clock divided by 1..64
// - halt with both keeps zero enters sleep, system clock stops
// - halt with fast keep 0, slow keep 1 enters idle0
// - halt with both keeps one enters idle1, both oscillators run
// - halt with fast keep 1, slow keep 0 enters idle2
// - halt leaves memory, registers and port states untouched
// - halt sets power-down flag and clears time-out flag
// - halt clears the watchdog counter
// - wake on enabled pin falling edge, interrupt, or watchdog overflow
// - power-down flag cleared on power-up and clear-watchdog
// - watchdog wake sets time-out, resets only program counter and stack
// - pin wake resumes after the halt instruction
// - disabled interrupt or full stack wake resumes after halt
// - enabled interrupt with stack room gets normal interrupt response
// - interrupt already pending at halt does not wake
// - select field is bits 7..5 of clock control, resets zero
// - bit 1 keeps fast, bit 0 keeps slow oscillator in halt, reset zero
module pmcm_top (
  input wire logic clk, // 100 MHz
  input wire logic rst, // async, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB unmapped address
  input wire pmcm_pkg::pmcm_cpu_t cpu, // cpu events and watchdog status
  input wire logic [7:0] irq_req, // interrupt request flags
  input wire logic [7:0] irq_en, // interrupt enables
  input wire logic [7:0] port_pin, // asynchronous port pins
  output logic sys_clk_en, // system clock enable pulse
  output logic fast_osc_on, // fast internal oscillator running
  output logic slow_osc_on, // slow internal oscillator running
  output logic cpu_run, // CPU may execute
  output pmcm_pkg::pmcm_mode_t power_mode, // current operating mode
  output logic wdt_clear, // pulse: clear watchdog counter
  output logic pc_sp_reset, // pulse: reset program counter and stack pointer
  output logic irq_take, // pulse: perform interrupt response
  output logic resume_next // pulse: continue after halt
);
  import pmcm_pkg::*;

  typedef struct packed {
    pmcm_state_t st;
    pmcm_mode_t mode;
    logic [2:0] sel;
    logic fkeep;
    logic skeep;
    logic hosc_en;
    logic [7:0] wake_en;
    logic power_down_flag;
    logic to;
    logic [CNT_W-1:0] fcnt;
    logic fstable;
    logic [CNT_W-1:0] scnt;
    logic sstable;
    logic [CNT_W-1:0] sdiv;
    logic stick;
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    logic [7:0] pin_s3;
    logic [7:0] pin_f;
    logic [7:0] irq_pre;
    logic wk_wdt;
    logic wk_pin;
    logic [7:0] wk_irq;
    logic fast_on;
    logic slow_on;
    logic cpu_run;
    logic wdt_clr;
    logic pcsp_rst;
    logic irq_take;
    logic resume;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pmcm_regs_t;

  pmcm_regs_t s_q, s_d;
  pmcm_div_ctl_t div_ctl;
  logic div_en;
  logic [2:0] div_sel;
  logic [7:0] agree;
  logic [7:0] pin_fall;
  logic [7:0] irq_new;
  logic wake_any;
  logic src_ok;
  logic acc;

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == OFS_SCC) || (a == OFS_HOSC) || (a == OFS_STATUS) || (a == OFS_WAKE);
  endfunction

  function automatic pmcm_mode_t halt_mode(input logic fk, input logic sk);
    unique case ({fk, sk})
      2'b00: halt_mode = MODE_SLEEP;
      2'b01: halt_mode = MODE_IDLE0;
      2'b11: halt_mode = MODE_IDLE1;
      2'b10: halt_mode = MODE_IDLE2;
    endcase
  endfunction

  always_comb begin
    s_d = s_q;
    s_d.wdt_clr = 1'b0;
    s_d.pcsp_rst = 1'b0;
    s_d.irq_take = 1'b0;
    s_d.resume = 1'b0;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    acc = psel & penable;

    // pins: a change counts once the second and third stages agree
    s_d.pin_s1 = port_pin;
    s_d.pin_s2 = s_q.pin_s1;
    s_d.pin_s3 = s_q.pin_s2;
    agree = ~(s_q.pin_s2 ^ s_q.pin_s3);
    s_d.pin_f = (s_q.pin_f & ~agree) | (s_q.pin_s3 & agree);
    pin_fall = s_q.pin_f & agree & ~s_q.pin_s3 & s_q.wake_en;

    // slow clock tick, only while the slow oscillator runs
    s_d.stick = 1'b0;
    if (s_q.slow_on) begin
      if (s_q.sdiv == STICK_LAST) begin
        s_d.sdiv = '0;
        s_d.stick = 1'b1;
      end else begin
        s_d.sdiv = s_q.sdiv + CNT_W'(1);
      end
    end

    // settle timers restart from zero each time an oscillator starts
    if (!s_q.fast_on) begin
      s_d.fcnt = '0;
      s_d.fstable = 1'b0;
    end else if (!s_q.fstable) begin
      if (s_q.fcnt == FAST_LAST) begin
        s_d.fstable = 1'b1;
      end else begin
        s_d.fcnt = s_q.fcnt + CNT_W'(1);
      end
    end
    if (!s_q.slow_on) begin
      s_d.scnt = '0;
      s_d.sstable = 1'b0;
    end else if (!s_q.sstable) begin
      if (s_q.scnt == SLOW_LAST) begin
        s_d.sstable = 1'b1;
      end else begin
        s_d.scnt = s_q.scnt + CNT_W'(1);
      end
    end

    // flags: the set is applied last so it wins over a clear
    if (cpu.clr_wdt) begin
      s_d.power_down_flag = 1'b0;
    end

    irq_new = irq_req & ~s_q.irq_pre;
    wake_any = (|pin_fall) | (|irq_new) | cpu.wdt_overflow;
    src_ok = (div_sel == SEL_SLOW) ? s_q.sstable : s_q.fstable;

    unique case (s_q.st)
      PMCM_RUN: begin
        s_d.mode = (div_sel == SEL_SLOW) ? MODE_SLOW : MODE_FAST;
        if (cpu.halt) begin
          // nothing else is touched, so memory, registers and ports hold
          s_d.st = PMCM_HALT;
          s_d.cpu_run = 1'b0;
          s_d.mode = halt_mode(s_q.fkeep, s_q.skeep);
          s_d.power_down_flag = 1'b1;
          s_d.to = 1'b0;
          s_d.wdt_clr = 1'b1;
          s_d.irq_pre = irq_req;
        end
      end
      PMCM_HALT: begin
        // a request that drops while halted is re-armed as a wake source
        s_d.irq_pre = s_q.irq_pre & irq_req;
        if (wake_any) begin
          s_d.st = PMCM_WAKE;
          s_d.wk_wdt = cpu.wdt_overflow;
          s_d.wk_pin = |pin_fall;
          s_d.wk_irq = irq_new;
        end
      end
      PMCM_WAKE: begin
        if (src_ok) begin
          s_d.st = PMCM_RUN;
          s_d.cpu_run = 1'b1;
          s_d.mode = (div_sel == SEL_SLOW) ? MODE_SLOW : MODE_FAST;
          s_d.wk_wdt = 1'b0;
          s_d.wk_pin = 1'b0;
          s_d.wk_irq = 8'h00;
          if (s_q.wk_wdt) begin
            s_d.pcsp_rst = 1'b1;
          end else if ((|(s_q.wk_irq & irq_en)) && !cpu.stack_full) begin
            s_d.irq_take = 1'b1;
          end else if (s_q.wk_pin || (|s_q.wk_irq)) begin
            s_d.resume = 1'b1;
          end
        end
      end
      default: begin
        s_d.st = PMCM_WAKE;
      end
    endcase

    if (cpu.wdt_overflow) begin
      s_d.to = 1'b1;
    end

    // APB: one wait state so that read data comes from a flip-flop
    if (acc && !s_q.pready) begin
      s_d.pready = 1'b1;
      s_d.pslverr = !reg_hit(paddr);
      s_d.prdata = 32'h0000_0000;
      unique case (paddr)
        OFS_SCC: begin
          s_d.prdata[SCC_SEL_LSB +: 3] = s_q.sel;
          s_d.prdata[SCC_FKEEP_BIT] = s_q.fkeep;
          s_d.prdata[SCC_SKEEP_BIT] = s_q.skeep;
        end
        OFS_HOSC: begin
          s_d.prdata[HOSC_STABLE_BIT] = s_q.fstable;
          s_d.prdata[HOSC_EN_BIT] = s_q.hosc_en;
        end
        OFS_STATUS: begin
          s_d.prdata[ST_PDF_BIT] = s_q.power_down_flag;
          s_d.prdata[ST_TO_BIT] = s_q.to;
        end
        OFS_WAKE: s_d.prdata[7:0] = s_q.wake_en;
        default: s_d.prdata = 32'h0000_0000;
      endcase
    end
    if (acc && s_q.pready && pwrite) begin
      unique case (paddr)
        OFS_SCC: begin
          s_d.sel = pwdata[SCC_SEL_LSB +: 3];
          s_d.fkeep = pwdata[SCC_FKEEP_BIT];
          s_d.skeep = pwdata[SCC_SKEEP_BIT];
        end
        OFS_HOSC: s_d.hosc_en = pwdata[HOSC_EN_BIT];
        OFS_WAKE: s_d.wake_en = pwdata[7:0];
        default: s_d.sel = s_q.sel;
      endcase
    end

    // oscillator gating; outside halt the running source and the requested one stay on, in halt the keep bits and the watchdog decide
    if (s_d.st == PMCM_HALT) begin
      s_d.fast_on = s_q.fkeep;
      s_d.slow_on = s_q.skeep | cpu.wdt_enabled;
    end else begin
      s_d.fast_on = s_d.hosc_en | (div_sel != SEL_SLOW) | (s_d.sel != SEL_SLOW);
      s_d.slow_on = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.st <= PMCM_WAKE; // power-up waits for the fast oscillator too
      s_q.mode <= MODE_FAST;
      s_q.sel <= SCC_SEL_RST;
      s_q.fkeep <= SCC_FKEEP_RST;
      s_q.skeep <= SCC_SKEEP_RST;
      s_q.hosc_en <= HOSC_EN_RST;
      s_q.wake_en <= WAKE_EN_RST;
      s_q.power_down_flag <= 1'b0;
      s_q.fast_on <= 1'b1;
      s_q.slow_on <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign div_ctl = '{sel: s_q.sel, fast_ok: s_q.fstable & s_q.fast_on,
                     slow_ok: s_q.sstable & s_q.slow_on, slow_tick: s_q.stick,
                     run: s_q.cpu_run};

  pmcm_sysclk_div u_div (
    .clk(clk),
    .rst(rst),
    .ctl(div_ctl),
    .sys_en(div_en),
    .cur_sel(div_sel)
  );

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign sys_clk_en = div_en;
  assign fast_osc_on = s_q.fast_on;
  assign slow_osc_on = s_q.slow_on;
  assign cpu_run = s_q.cpu_run;
  assign power_mode = s_q.mode;
  assign wdt_clear = s_q.wdt_clr;
  assign pc_sp_reset = s_q.pcsp_rst;
  assign irq_take = s_q.irq_take;
  assign resume_next = s_q.resume;

  sequence seq_halt_entry;
    s_q.st == PMCM_RUN && cpu.halt;
  endsequence

  sequence seq_wake_done;
    s_q.st == PMCM_WAKE ##1 s_q.st == PMCM_RUN;
  endsequence

  AST_STABLE_CLEARED: assert property (@(posedge clk) disable iff (rst)
    $rose(s_q.fast_on) |-> !s_q.fstable [*8])
    else $error("stable flag not held low after oscillator start");
  AST_HOSC_UPPER_ZERO: assert property (@(posedge clk) disable iff (rst)
    s_q.pready && !pwrite && paddr == OFS_HOSC |-> s_q.prdata[31:2] == 30'h0)
    else $error("fast oscillator control upper bits not zero");
  AST_SLEEP_ENTRY: assert property (@(posedge clk) disable iff (rst)
    seq_halt_entry and !s_q.fkeep && !s_q.skeep |=>
      s_q.mode == MODE_SLEEP && !s_q.cpu_run && !s_q.fast_on ##1 !div_en)
    else $error("sleep entry wrong");
  AST_IDLE0_ENTRY: assert property (@(posedge clk) disable iff (rst)
    seq_halt_entry and !s_q.fkeep && s_q.skeep |=>
      s_q.mode == MODE_IDLE0 && !s_q.fast_on && s_q.slow_on)
    else $error("idle0 entry wrong");
  AST_IDLE1_ENTRY: assert property (@(posedge clk) disable iff (rst)
    seq_halt_entry and s_q.fkeep && s_q.skeep |=>
      s_q.mode == MODE_IDLE1 && s_q.fast_on && s_q.slow_on && !s_q.cpu_run)
    else $error("idle1 entry wrong");
  AST_IDLE2_ENTRY: assert property (@(posedge clk) disable iff (rst)
    seq_halt_entry and s_q.fkeep && !s_q.skeep && !cpu.wdt_enabled |=>
      s_q.mode == MODE_IDLE2 && s_q.fast_on && !s_q.slow_on)
    else $error("idle2 entry wrong");
  AST_HALT_FLAGS: assert property (@(posedge clk) disable iff (rst)
    seq_halt_entry and !cpu.wdt_overflow |=> s_q.power_down_flag && !s_q.to && s_q.wdt_clr)
    else $error("halt entry flags wrong");
  AST_PDF_CLEAR: assert property (@(posedge clk) disable iff (rst)
    cpu.clr_wdt && !(s_q.st == PMCM_RUN && cpu.halt) |=> !s_q.power_down_flag)
    else $error("power-down flag not cleared");
  AST_WDT_WAKE: assert property (@(posedge clk) disable iff (rst)
    s_q.st == PMCM_HALT && cpu.wdt_overflow |=> s_q.to && s_q.st == PMCM_WAKE)
    else $error("watchdog wake did not set time-out");
  AST_PRESET_IRQ: assert property (@(posedge clk) disable iff (rst)
    s_q.st == PMCM_HALT && pin_fall == 8'h00 && !cpu.wdt_overflow &&
      (irq_req & ~s_q.irq_pre) == 8'h00 |=> s_q.st == PMCM_HALT)
    else $error("pending interrupt woke the device");
  AST_RESUME_STABLE: assert property (@(posedge clk) disable iff (rst)
    seq_wake_done |-> s_q.cpu_run && $past(src_ok))
    else $error("CPU resumed before oscillator stable");
endmodule

// File: common/pmcm_pkg.sv
// constants, types and register map of the power-mode and clock manager
package pmcm_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CNT_W = 12;
  localparam int FAST_SETTLE_NS = 15000;
  localparam int FAST_SETTLE_CYC = (FAST_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLOW_SETTLE_NS = 40000;
  localparam int SLOW_SETTLE_CYC = (SLOW_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLOW_PERIOD_NS = 31250;
  localparam int SLOW_PERIOD_CYC = SLOW_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] FAST_LAST = CNT_W'(FAST_SETTLE_CYC - 1);
  localparam logic [CNT_W-1:0] SLOW_LAST = CNT_W'(SLOW_SETTLE_CYC - 1);
  localparam logic [CNT_W-1:0] STICK_LAST = CNT_W'(SLOW_PERIOD_CYC - 1);

  localparam logic [7:0] OFS_SCC = 8'h00;
  localparam logic [7:0] OFS_HOSC = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_WAKE = 8'h0c;

  localparam int SCC_SEL_LSB = 5;
  localparam int SCC_FKEEP_BIT = 1;
  localparam int SCC_SKEEP_BIT = 0;
  localparam int HOSC_EN_BIT = 0;
  localparam int HOSC_STABLE_BIT = 1;
  localparam int ST_PDF_BIT = 0;
  localparam int ST_TO_BIT = 1;

  localparam logic [2:0] SCC_SEL_RST = 3'h0;
  localparam logic SCC_FKEEP_RST = 1'b0;
  localparam logic SCC_SKEEP_RST = 1'b0;
  localparam logic HOSC_EN_RST = 1'b1;
  localparam logic [7:0] WAKE_EN_RST = 8'h00;
  localparam logic [2:0] SEL_SLOW = 3'h7;

  typedef enum logic [1:0] {
    PMCM_RUN = 2'b00,
    PMCM_HALT = 2'b01,
    PMCM_WAKE = 2'b10
  } pmcm_state_t;

  typedef enum logic [2:0] {
    MODE_FAST = 3'b000,
    MODE_SLOW = 3'b001,
    MODE_SLEEP = 3'b010,
    MODE_IDLE0 = 3'b011,
    MODE_IDLE1 = 3'b100,
    MODE_IDLE2 = 3'b101
  } pmcm_mode_t;

  typedef struct packed {
    logic halt;
    logic clr_wdt;
    logic wdt_enabled;
    logic wdt_overflow;
    logic stack_full;
  } pmcm_cpu_t;

  typedef struct packed {
    logic [2:0] sel;
    logic fast_ok;
    logic slow_ok;
    logic slow_tick;
    logic run;
  } pmcm_div_ctl_t;
endpackage

// File: rtl/pmcm_sysclk_div.sv
// system clock enable divider with boundary-only source and ratio switching
`timescale 1ns/100ps
module pmcm_sysclk_div (
  input wire logic clk, // 100 MHz
  input wire logic rst, // async, active high
  input wire pmcm_pkg::pmcm_div_ctl_t ctl, // requested select and source status
  output logic sys_en, // one-cycle system clock enable
  output logic [2:0] cur_sel // select now in force
);
  import pmcm_pkg::*;

  typedef struct packed {
    logic [5:0] cnt;
    logic [2:0] sel;
    logic en;
  } pmcm_div_st_t;

  pmcm_div_st_t s_q, s_d;
  logic src_tick;

  function automatic logic [5:0] div_last(input logic [2:0] sel);
    div_last = (sel == SEL_SLOW) ? 6'h00 : 6'((7'h01 << sel) - 7'h01);
  endfunction

  always_comb begin
    s_d = s_q;
    s_d.en = 1'b0;
    src_tick = (s_q.sel == SEL_SLOW) ? (ctl.slow_tick & ctl.slow_ok) : ctl.fast_ok;
    if (ctl.run && src_tick) begin
      if (s_q.cnt >= div_last(s_q.sel)) begin
        s_d.en = 1'b1;
        s_d.cnt = 6'h00;
        // adopt only at a period end and only onto a settled source
        if (ctl.sel != s_q.sel && ((ctl.sel == SEL_SLOW) ? ctl.slow_ok : ctl.fast_ok)) begin
          s_d.sel = ctl.sel;
        end
      end else begin
        s_d.cnt = s_q.cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '{cnt: 6'h00, sel: SCC_SEL_RST, en: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign sys_en = s_q.en;
  assign cur_sel = s_q.sel;

  AST_SLOW_NEEDS_STABLE: assert property (@(posedge clk) disable iff (rst)
    (s_q.sel != SEL_SLOW) ##1 (s_q.sel == SEL_SLOW) |-> $past(ctl.slow_ok))
    else $error("switched to slow clock before it was stable");
  AST_NO_SHORT_PERIOD: assert property (@(posedge clk) disable iff (rst)
    s_q.en && $past(s_q.en) |-> $past(s_q.sel) == 3'h0)
    else $error("system clock enable period shortened");
endmodule

// File: test/pmcm_tb.sv
// self-checking bench of the power-mode and clock manager
`timescale 1ns/100ps
module pmcm_tb;
  import pmcm_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, irq_req, irq_en, port_pin;
  logic [31:0] pwdata, prdata, rd;
  logic err;
  pmcm_cpu_t cpu;
  logic sys_clk_en, fast_osc_on, slow_osc_on, cpu_run;
  logic wdt_clear, pc_sp_reset, irq_take, resume_next;
  pmcm_mode_t power_mode;
  pmcm_mode_t mt [4];
  int fail_count, tests_run, p, k;
  // register model
  int scc_m, en_m, stable_m, wake_m, pdf_m, to_m;

  pmcm_top uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu(cpu), .irq_req(irq_req), .irq_en(irq_en), .port_pin(port_pin),
    .sys_clk_en(sys_clk_en), .fast_osc_on(fast_osc_on), .slow_osc_on(slow_osc_on),
    .cpu_run(cpu_run), .power_mode(power_mode), .wdt_clear(wdt_clear),
    .pc_sp_reset(pc_sp_reset), .irq_take(irq_take), .resume_next(resume_next));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic final_report();
    if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one full transfer; signals held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk(n < 20, 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] exp_rd(input logic [7:0] a);
    case (a)
      OFS_SCC: return 32'(scc_m);
      OFS_HOSC: return 32'((stable_m << HOSC_STABLE_BIT) | (en_m << HOSC_EN_BIT));
      OFS_STATUS: return 32'((to_m << ST_TO_BIT) | (pdf_m << ST_PDF_BIT));
      OFS_WAKE: return 32'(wake_m);
      default: return 32'h0;
    endcase
  endfunction

  task automatic rd_chk(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
    chk(rd, exp_rd(a));
    chk(err, !(a inside {OFS_SCC, OFS_HOSC, OFS_STATUS, OFS_WAKE}));
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    if (a == OFS_SCC) scc_m = int'(d[7:0] & 8'he3);
    if (a == OFS_HOSC) en_m = int'(d[0]);
    if (a == OFS_WAKE) wake_m = int'(d[7:0]);
  endtask

  task automatic do_halt();
    @(posedge clk);
    cpu.halt <= 1'b1;
    @(posedge clk);
    cpu.halt <= 1'b0;
    @(posedge clk);
    pdf_m = 1;
    to_m = 0;
  endtask

  // pulses are looked at in the cycle cpu_run first reads high
  task automatic wait_run(input logic [2:0] exp);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (cpu_run !== 1'b1 && n < 9000);
    chk(n < 9000, 1'b1);
    chk({pc_sp_reset, irq_take, resume_next}, exp);
  endtask

  task automatic pin_wake();
    @(posedge clk);
    port_pin[k] <= 1'b0;
    wait_run(3'b001);
    @(posedge clk);
    port_pin <= 8'hff;
  endtask

  // skips three enables: a slow source starts on a partial tick period
  task automatic per(input int lim);
    int n;
    repeat (4) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (sys_clk_en !== 1'b1 && n < lim);
    end
    p = n;
  endtask

  initial begin
    #1_000_000;
    fail_count++;
    final_report();
  end

  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    cpu = '0;
    irq_req = 8'h00;
    irq_en = 8'h00;
    port_pin = 8'hff;
    fail_count = 0;
    tests_run = 0;
    scc_m = 0;
    en_m = 1;
    stable_m = 0;
    wake_m = 0;
    pdf_m = 0;
    to_m = 0;
    mt[0] = MODE_SLEEP;
    mt[1] = MODE_IDLE0;
    mt[2] = MODE_IDLE2;
    mt[3] = MODE_IDLE1;
    void'($urandom(32'hb642c8a7));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd_chk(OFS_HOSC);
    rd_chk(OFS_SCC);
    rd_chk(OFS_STATUS);
    rd_chk(OFS_WAKE);
    rd_chk(8'h10);
    wait_run(3'b000);
    stable_m = 1;
    wr(OFS_HOSC, $urandom | 32'h1);
    rd_chk(OFS_HOSC);
    k = int'($urandom % 8);
    wr(OFS_WAKE, 32'h1 << k);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_SCC, ($urandom & 32'hffff_ff1c) | i);
      // sleep with the watchdog on must keep the slow oscillator running
      cpu.wdt_enabled <= (i == 0);
      do_halt();
      chk(power_mode, mt[i]);
      chk({cpu_run, wdt_clear}, 2'b01);
      chk({fast_osc_on, slow_osc_on}, {i[1], i[0] | (i == 0)});
      rd_chk(OFS_STATUS);
      rd_chk(OFS_SCC);
      pin_wake();
      chk(power_mode, MODE_FAST);
    end
    wr(OFS_SCC, 32'h3);
    do_halt();
    @(posedge clk);
    cpu.wdt_overflow <= 1'b1;
    @(posedge clk);
    cpu.wdt_overflow <= 1'b0;
    to_m = 1;
    wait_run(3'b100);
    rd_chk(OFS_STATUS);
    @(posedge clk);
    cpu.clr_wdt <= 1'b1;
    @(posedge clk);
    cpu.clr_wdt <= 1'b0;
    pdf_m = 0;
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[ST_PDF_BIT], 1'b0);
    chk(rd, exp_rd(OFS_STATUS));
    irq_en <= 8'h04;
    for (int sf = 0; sf < 2; sf++) begin
      cpu.stack_full <= sf[0];
      do_halt();
      irq_req <= 8'h04;
      wait_run(sf ? 3'b001 : 3'b010);
      @(posedge clk);
      irq_req <= 8'h00;
    end
    @(posedge clk);
    irq_en <= 8'h02;
    irq_req <= 8'h02;
    do_halt();
    repeat (50) @(posedge clk);
    chk(cpu_run, 1'b0);
    pin_wake();
    irq_req <= 8'h00;
    for (int s = 0; s < 7; s++) begin
      wr(OFS_SCC, 32'(s) << SCC_SEL_LSB);
      per(200);
      chk(p, 1 << s);
    end
    wr(OFS_SCC, 32'(SEL_SLOW) << SCC_SEL_LSB);
    // slow oscillator restarted at the idle2 wake and has not settled yet
    per(200);
    chk(p, 64);
    chk(power_mode, MODE_FAST);
    repeat (SLOW_SETTLE_CYC) @(posedge clk);
    per(20000);
    chk(p, SLOW_PERIOD_CYC);
    chk(power_mode, MODE_SLOW);
    wr(OFS_HOSC, 32'h0);
    stable_m = 0;
    rd_chk(OFS_HOSC);
    wr(OFS_HOSC, 32'h1);
    rd_chk(OFS_HOSC);
    repeat (FAST_SETTLE_CYC + 20) @(posedge clk);
    stable_m = 1;
    rd_chk(OFS_HOSC);
    wr(OFS_SCC, 32'h0);
    per(4000);
    chk(p, 1);
    chk(power_mode, MODE_FAST);
    final_report();
  end
endmodule
